// file: npx_pkg.sv
// constants for the numeric coprocessor host glue
// assumes one 25 MHz clock and asynchronous active-low reset
package npx_pkg;
  // personality select encoding
  localparam logic mode_cache = 1'b0;
  localparam logic mode_extcop = 1'b1;
  // coprocessor flavour in external mode
  localparam logic cop_standard = 1'b0;
  localparam logic cop_third_party = 1'b1;
  // reset values of outputs (active-low pins idle high)
  localparam logic rst_high = 1'b1;
  localparam logic rst_low = 1'b0;
  // cache invalidate strobe width in clock cycles
  localparam int strobe_cycles = 1;
  // port decode: address bit 0 value for each port
  localparam logic port_clear_a0 = 1'b0; // port f0
  localparam logic port_ignore_a0 = 1'b1; // port f1
  // byte enable width
  localparam int be_width = 4;
  localparam logic [3:0] be_all_off = 4'hf;
endpackage : npx_pkg

// file: sync2.sv
// two-flop synchroniser for one asynchronous level
// assumes input is from outside the clock domain
`timescale 1ns/100ps
module sync2 #(
  parameter logic reset_value = 1'b1
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic async_i,
  output logic sync_o
);
  logic stage1;
  // first stage read only by the second
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      stage1 <= reset_value;
      sync_o <= reset_value;
    end
    else
    begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule : sync2

// file: io_write_decode.sv
// decodes an i/o write to one coprocessor port as a single-cycle pulse
// assumes synchronised active-low select, write strobe and address bit 0
`timescale 1ns/100ps
module io_write_decode #(
  parameter logic match_a0 = 1'b0
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic port_select_n_i,
  input wire logic io_write_n_i,
  input wire logic addr0_i,
  output logic hit_o
);
  logic hit_level;
  logic hit_prev;
  logic next_hit_prev;
  // level true while select and write low and a0 matches
  always_comb
  begin
    hit_level = !port_select_n_i && !io_write_n_i && (addr0_i == match_a0);
    next_hit_prev = hit_level;
    hit_o = hit_level && !hit_prev;
  end
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      hit_prev <= npx_pkg::rst_low;
    else
      hit_prev <= next_hit_prev;
  end
endmodule : io_write_decode

// file: npx_glue.sv
// Function
// - cache mode: cpu bus request feeds the miss indication
// - external mode: address bit 31 decodes coprocessor i/o at top
// - cache mode: cache enable sampled on reads overrides byte enables
// - external mode: error and busy make busy, extension request, interrupt
// - external mode: busy output active while coprocessor busy or error has occurred
// - external mode: during cpu reset, error input sampled to detect coprocessor presence
// - coprocessor present: error output low from reset until first cycle
// - otherwise in external mode error output follows coprocessor error
// - cache mode: write to f1 sets ignore error, held while error active
// - coprocessor interrupt set when error input signals an error
// - i/o write to f0 clears coprocessor interrupt
// - interrupt input joins interrupt logic in cache or third-party mode
// - standard coprocessor: extension request input feeds cpu request
// - extension request tells cpu operands ready; unused in cache mode
// - one-cycle invalidate strobe per external master memory write
// - no invalidate strobe on master reads, nor in external mode
// - miss asserted in hold acknowledge for pending unclaimed host access
// - miss also asserted on host hold request, or on bus request in cache mode
//
// top of the coprocessor glue; one clock, no software registers
// assumes pins are asynchronous and active-low pins idle high
`timescale 1ns/100ps
module npx_glue (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic mode_select_i,
  input wire logic cop_type_i,
  input wire logic request_addr31_i,
  input wire logic kenn_busyn_i,
  input wire logic coprocessor_error_n_i,
  input wire logic intr_pereq_i,
  input wire logic coprocessor_port_select_n_i,
  input wire logic io_write_n_i,
  input wire logic addr0_i,
  input wire logic cpu_reset_output_i,
  input wire logic cpu_bus_cycle_n_i,
  input wire logic cpu_read_i,
  input wire logic [3:0] host_byte_enables_n_i,
  input wire logic host_hold_request_i,
  input wire logic refresh_hold_ack_i,
  input wire logic host_access_pending_i,
  input wire logic local_claim_n_i,
  input wire logic master_write_i,
  input wire logic master_addr_stable_i,
  output logic cpu_miss_indication_n_o,
  output logic coprocessor_access_o,
  output logic [3:0] effective_byte_enables_n_o,
  output logic cpu_busy_n_o,
  output logic cpu_extension_request_o,
  output logic err_ign_n_o,
  output logic coprocessor_interrupt_o,
  output logic cache_invalidate_strobe_n_o
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic mode_s, cop_type_s, req_a31_s, kenn_busyn_s, err_n_s, intr_pereq_s;
  logic ps_n_s, iow_n_s, a0_s, rst_out_s, cyc_n_s, rd_s;
  logic hold_s, rdhlda_s, pend_s, claim_n_s, mwr_s, mstable_s;
  logic [3:0] be_n_s;

  // one synchroniser per active-low or idle-high pin
  sync2 #(.reset_value(npx_pkg::rst_high)) u_s_kenbusy (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .async_i(kenn_busyn_i),
    .sync_o(kenn_busyn_s)
  );
  sync2 #(.reset_value(npx_pkg::rst_high)) u_s_err (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .async_i(coprocessor_error_n_i),
    .sync_o(err_n_s)
  );
  sync2 #(.reset_value(npx_pkg::rst_high)) u_s_ps (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .async_i(coprocessor_port_select_n_i),
    .sync_o(ps_n_s)
  );
  sync2 #(.reset_value(npx_pkg::rst_high)) u_s_iow (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .async_i(io_write_n_i),
    .sync_o(iow_n_s)
  );
  sync2 #(.reset_value(npx_pkg::rst_high)) u_s_cyc (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .async_i(cpu_bus_cycle_n_i),
    .sync_o(cyc_n_s)
  );
  sync2 #(.reset_value(npx_pkg::rst_high)) u_s_claim (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .async_i(local_claim_n_i),
    .sync_o(claim_n_s)
  );

  // active-high pins idle low
  sync2 #(.reset_value(npx_pkg::rst_low)) u_s_mode (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .async_i(mode_select_i),
    .sync_o(mode_s)
  );
  sync2 #(.reset_value(npx_pkg::rst_low)) u_s_type (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .async_i(cop_type_i),
    .sync_o(cop_type_s)
  );
  sync2 #(.reset_value(npx_pkg::rst_low)) u_s_req (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .async_i(request_addr31_i),
    .sync_o(req_a31_s)
  );
  sync2 #(.reset_value(npx_pkg::rst_low)) u_s_intr (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .async_i(intr_pereq_i),
    .sync_o(intr_pereq_s)
  );
  sync2 #(.reset_value(npx_pkg::rst_low)) u_s_a0 (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .async_i(addr0_i),
    .sync_o(a0_s)
  );
  sync2 #(.reset_value(npx_pkg::rst_low)) u_s_rst (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .async_i(cpu_reset_output_i),
    .sync_o(rst_out_s)
  );
  sync2 #(.reset_value(npx_pkg::rst_low)) u_s_rd (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .async_i(cpu_read_i),
    .sync_o(rd_s)
  );
  sync2 #(.reset_value(npx_pkg::rst_low)) u_s_hold (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .async_i(host_hold_request_i),
    .sync_o(hold_s)
  );
  sync2 #(.reset_value(npx_pkg::rst_low)) u_s_hlda (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .async_i(refresh_hold_ack_i),
    .sync_o(rdhlda_s)
  );
  sync2 #(.reset_value(npx_pkg::rst_low)) u_s_pend (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .async_i(host_access_pending_i),
    .sync_o(pend_s)
  );
  sync2 #(.reset_value(npx_pkg::rst_low)) u_s_mwr (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .async_i(master_write_i),
    .sync_o(mwr_s)
  );
  sync2 #(.reset_value(npx_pkg::rst_low)) u_s_mst (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .async_i(master_addr_stable_i),
    .sync_o(mstable_s)
  );

  // byte enables, one synchroniser per lane
  genvar gi;
  generate
    for (gi = 0; gi < npx_pkg::be_width; gi++)
    begin : g_be
      sync2 #(.reset_value(npx_pkg::rst_high)) u_s_be (.sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i), .async_i(host_byte_enables_n_i[gi]),
        .sync_o(be_n_s[gi]));
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // port write decodes
  logic clear_hit, ignore_hit;

  io_write_decode #(.match_a0(npx_pkg::port_clear_a0)) u_dec_f0 (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .port_select_n_i(ps_n_s),
    .io_write_n_i(iow_n_s), .addr0_i(a0_s), .hit_o(clear_hit));
  io_write_decode #(.match_a0(npx_pkg::port_ignore_a0)) u_dec_f1 (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .port_select_n_i(ps_n_s),
    .io_write_n_i(iow_n_s), .addr0_i(a0_s), .hit_o(ignore_hit));

  ////////////////////////////////////////////////////////////////////////////
  // state and outputs
  logic ext_mode, err_act, busy_act;
  logic present, in_reset_win, err_latched, ignore_on, mwr_done, rst_prev;
  logic next_present, next_in_reset_win, next_err_latched, next_ignore_on;
  logic next_mwr_done, next_rst_prev;
  logic next_miss_n, next_cop_acc, next_busy_n, next_pereq, next_err_o;
  logic next_int, next_inval_n;
  logic [3:0] next_be_n;

  always_comb
  begin
    ext_mode = (mode_s == npx_pkg::mode_extcop);
    err_act = !err_n_s;
    busy_act = !kenn_busyn_s && ext_mode;
    next_rst_prev = rst_out_s;
    // presence detect while cpu reset is held
    next_present = present;
    if (rst_out_s && ext_mode)
      next_present = err_act;
    // window from reset leading edge to first bus cycle
    next_in_reset_win = in_reset_win;
    if (rst_out_s && !rst_prev)
      next_in_reset_win = 1'b1;
    else if (!rst_out_s && !cyc_n_s)
      next_in_reset_win = 1'b0;
    // error condition latched until port f0 write; set wins
    next_err_latched = err_latched;
    if (err_act)
      next_err_latched = 1'b1;
    else if (clear_hit)
      next_err_latched = 1'b0;
    // ignore error set by port f1 write, kept while error active
    next_ignore_on = ignore_on;
    if (ext_mode)
      next_ignore_on = 1'b0;
    else if (ignore_hit)
      next_ignore_on = 1'b1;
    else if (!err_act)
      next_ignore_on = 1'b0;
    // interrupt: set by error or cache/third-party interrupt input
    next_int = coprocessor_interrupt_o;
    if (err_act || ((!ext_mode || cop_type_s == npx_pkg::cop_third_party)
        && intr_pereq_s))
      next_int = 1'b1;
    else if (clear_hit)
      next_int = 1'b0;
    // busy and extension request in external mode
    next_busy_n = !(ext_mode && (busy_act || err_latched));
    next_pereq = ext_mode && cop_type_s == npx_pkg::cop_standard
      && intr_pereq_s && !err_latched;
    // shared error/ignore pin
    if (ext_mode)
    begin
      if (in_reset_win && present)
        next_err_o = 1'b0;
      else
        next_err_o = err_n_s;
    end
    else
      next_err_o = !ignore_on;
    // coprocessor i/o decode at top of space
    next_cop_acc = ext_mode && req_a31_s;
    // cache enable overrides byte enables on reads
    next_be_n = be_n_s;
    if (!ext_mode && rd_s && !kenn_busyn_s)
      next_be_n = 4'h0;
    // miss indication
    next_miss_n = !((rdhlda_s && pend_s && claim_n_s)
      || hold_s || (!ext_mode && req_a31_s));
    // one strobe per master memory write while address stable
    next_mwr_done = mwr_done;
    next_inval_n = 1'b1;
    if (!mwr_s)
      next_mwr_done = 1'b0;
    else if (!ext_mode && mstable_s && !mwr_done)
    begin
      next_inval_n = 1'b0;
      next_mwr_done = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      present <= npx_pkg::rst_low;
      in_reset_win <= npx_pkg::rst_low;
      err_latched <= npx_pkg::rst_low;
      ignore_on <= npx_pkg::rst_low;
      mwr_done <= npx_pkg::rst_low;
      rst_prev <= npx_pkg::rst_low;
      cpu_miss_indication_n_o <= npx_pkg::rst_high;
      coprocessor_access_o <= npx_pkg::rst_low;
      effective_byte_enables_n_o <= npx_pkg::be_all_off;
      cpu_busy_n_o <= npx_pkg::rst_high;
      cpu_extension_request_o <= npx_pkg::rst_low;
      err_ign_n_o <= npx_pkg::rst_high;
      coprocessor_interrupt_o <= npx_pkg::rst_low;
      cache_invalidate_strobe_n_o <= npx_pkg::rst_high;
    end
    else
    begin
      present <= next_present;
      in_reset_win <= next_in_reset_win;
      err_latched <= next_err_latched;
      ignore_on <= next_ignore_on;
      mwr_done <= next_mwr_done;
      rst_prev <= next_rst_prev;
      cpu_miss_indication_n_o <= next_miss_n;
      coprocessor_access_o <= next_cop_acc;
      effective_byte_enables_n_o <= next_be_n;
      cpu_busy_n_o <= next_busy_n;
      cpu_extension_request_o <= next_pereq;
      err_ign_n_o <= next_err_o;
      coprocessor_interrupt_o <= next_int;
      cache_invalidate_strobe_n_o <= next_inval_n;
    end
  end
endmodule : npx_glue

// file: npx_glue_chk.sv
// checker: output timing of the coprocessor glue against its pins
// assumes a bind into npx_glue and inputs moved off the rising edge
`timescale 1ns/100ps
module npx_glue_chk (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic mode_select_i,
  input wire logic request_addr31_i,
  input wire logic kenn_busyn_i,
  input wire logic coprocessor_error_n_i,
  input wire logic host_hold_request_i,
  input wire logic master_write_i,
  input wire logic coprocessor_access_o,
  input wire logic cpu_miss_indication_n_o,
  input wire logic cpu_busy_n_o,
  input wire logic cpu_extension_request_o,
  input wire logic coprocessor_interrupt_o,
  input wire logic cache_invalidate_strobe_n_o
);
  // one clock domain; reset drops every open attempt
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);
  strobe_width_a:
    assert property (!cache_invalidate_strobe_n_o |=>
      cache_invalidate_strobe_n_o) else $error("strobe too long");
  strobe_cause_a:
    assert property (!cache_invalidate_strobe_n_o |->
      $past(master_write_i, 3)) else $error("strobe without write");
  strobe_ext_a:
    assert property (mode_select_i [*4] |=> cache_invalidate_strobe_n_o)
      else $error("strobe in external mode");
  busy_set_a:
    assert property ((mode_select_i && !kenn_busyn_i) [*4] |=>
      !cpu_busy_n_o) else $error("busy not passed on");
  cache_quiet_a:
    assert property (!mode_select_i [*4] |=>
      (cpu_busy_n_o && !cpu_extension_request_o)) else $error("cache busy");
  int_set_a:
    assert property (!coprocessor_error_n_i [*4] |=>
      coprocessor_interrupt_o) else $error("interrupt not raised");
  access_dec_a:
    assert property ((mode_select_i && request_addr31_i) [*4] |=>
      coprocessor_access_o) else $error("access not decoded");
  miss_hold_a:
    assert property (host_hold_request_i [*4] |=> !cpu_miss_indication_n_o)
      else $error("miss not raised on hold");
endmodule : npx_glue_chk
////////////////////////////////////////////////////////////////////////////
bind npx_glue npx_glue_chk i_chk (
  .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .mode_select_i(mode_select_i),
  .request_addr31_i(request_addr31_i), .kenn_busyn_i(kenn_busyn_i),
  .coprocessor_error_n_i(coprocessor_error_n_i),
  .host_hold_request_i(host_hold_request_i),
  .master_write_i(master_write_i),
  .coprocessor_access_o(coprocessor_access_o),
  .cpu_miss_indication_n_o(cpu_miss_indication_n_o),
  .cpu_busy_n_o(cpu_busy_n_o),
  .cpu_extension_request_o(cpu_extension_request_o),
  .coprocessor_interrupt_o(coprocessor_interrupt_o),
  .cache_invalidate_strobe_n_o(cache_invalidate_strobe_n_o));

// file: npx_cop_model.sv
// coprocessor model: presence on reset, busy run, request and error
// assumes its controls change at the falling clock edge
`timescale 1ns/100ps
module npx_cop_model (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic cpu_reset_i,
  input wire logic present_i,
  input wire logic op_i,
  input wire logic fail_i,
  output logic busy_n_o,
  output logic error_n_o,
  output logic pereq_o
);
  logic [3:0] cnt;
  logic err;
  // eight-cycle busy run; a failing run ends in an error held by fail_i
  always_ff @(posedge sys_clk_i or negedge rstn_i)
    if (!rstn_i)
    begin
      cnt <= 4'h0;
      err <= 1'b0;
    end
    else
    begin
      cnt <= (op_i && cnt == 4'h0) ? 4'h8 :
        (cnt == 4'h0) ? cnt : cnt - 4'h1;
      err <= fail_i && (err || cnt == 4'h1);
    end
  // a fitted part pulls its error pin low while the cpu is in reset
  assign error_n_o = cpu_reset_i ? !present_i : !err;
  assign busy_n_o = cnt == 4'h0;
  assign pereq_o = cnt != 4'h0 && !fail_i;
endmodule : npx_cop_model

// file: tb_top.sv
// testbench: one task per scenario for the coprocessor glue
// assumes the coprocessor model and the checker are compiled with it
`timescale 1ns/100ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
  n_mismatch++; $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_top;
  logic sys_clk_i, rstn_i, mode, ctype, ken_n, intr, cs_n, wr_n, a0, bus_req;
  logic cpu_rst, cyc_n, rd, hold, ack, pend, claim_n, mw, stab, present;
  logic op, fail, p_busy_n, p_err_n, p_req;
  logic [3:0] be_n, ebe_n;
  logic miss_n, acc, busy_n, req, err_n, irq, inv_n;
  int n_mismatch, compares, c;
  // shared pins: busy or cache enable, request or interrupt
  wire logic kb = mode ? p_busy_n : ken_n;
  wire logic ir = (mode && !ctype) ? p_req : intr;
  initial
  begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  npx_glue i_dut (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .mode_select_i(mode),
    .cop_type_i(ctype), .request_addr31_i(bus_req), .kenn_busyn_i(kb),
    .coprocessor_error_n_i(p_err_n), .intr_pereq_i(ir),
    .coprocessor_port_select_n_i(cs_n), .io_write_n_i(wr_n),
    .addr0_i(a0), .cpu_reset_output_i(cpu_rst), .cpu_bus_cycle_n_i(cyc_n),
    .cpu_read_i(rd), .host_byte_enables_n_i(be_n),
    .host_hold_request_i(hold), .refresh_hold_ack_i(ack),
    .host_access_pending_i(pend), .local_claim_n_i(claim_n),
    .master_write_i(mw), .master_addr_stable_i(stab),
    .cpu_miss_indication_n_o(miss_n), .coprocessor_access_o(acc),
    .effective_byte_enables_n_o(ebe_n), .cpu_busy_n_o(busy_n),
    .cpu_extension_request_o(req), .err_ign_n_o(err_n),
    .coprocessor_interrupt_o(irq), .cache_invalidate_strobe_n_o(inv_n));
  npx_cop_model i_cop (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .cpu_reset_i(cpu_rst),
    .present_i(present), .op_i(op), .fail_i(fail), .busy_n_o(p_busy_n),
    .error_n_o(p_err_n), .pereq_o(p_req));
  ////////////////////////////////////////////////////////////////////////
  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask : wt
  // port write, select and strobe held three cycles
  task automatic iow(input logic a);
    {cs_n, wr_n, a0} = {2'b00, a};
    wt(3);
    {cs_n, wr_n} = 2'b11;
    wt(5);
  endtask : iow
  // starts one coprocessor operation
  task automatic run(input logic f);
    {fail, op} = {f, 1'b1};
    wt(1);
    op = 1'b0;
  endtask : run
  task automatic t_ken;
    {be_n, rd, ken_n} = {4'ha, 2'b00};
    wt(5);
    `CHK("be", 4'ha, ebe_n)
    rd = 1'b1;
    wt(5);
    `CHK("ken", 4'h0, ebe_n)
    ken_n = 1'b1;
    wt(5);
    `CHK("nok", 4'ha, ebe_n)
    rd = 1'b0;
    $display("test ken done");
  endtask : t_ken
  task automatic mchk(input logic [4:0] v, input logic e);
    {hold, bus_req, ack, pend, claim_n} = v;
    wt(5);
    `CHK("miss", e, miss_n)
  endtask : mchk
  task automatic t_miss;
    mchk(5'h10, 1'b0);
    mchk(5'h08, 1'b0);
    `CHK("noacc", 1'b0, acc)
    mchk(5'h07, 1'b0);
    mchk(5'h06, 1'b1);
    mchk(5'h03, 1'b1);
    mode = 1'b1;
    mchk(5'h08, 1'b1);
    `CHK("acc", 1'b1, acc)
    {mode, bus_req} = 2'b00;
    $display("test miss done");
  endtask : t_miss
  task automatic cnt_inv;
    c = 0;
    repeat (10)
    begin
      wt(1);
      if (inv_n === 1'b0) c++;
    end
  endtask : cnt_inv
  task automatic t_inv;
    stab = 1'b1;
    repeat (2)
    begin
      mw = 1'b1;
      cnt_inv();
      `CHK("inv", 1, c)
      mw = 1'b0;
      cnt_inv();
      `CHK("rd", 0, c)
    end
    {mode, mw} = 2'b11;
    cnt_inv();
    `CHK("ext", 0, c)
    {mode, mw, stab} = 3'b000;
    $display("test strobe done");
  endtask : t_inv
  task automatic t_ign;
    run(1'b1);
    wt(14);
    `CHK("noign", 2'h3, {err_n, irq})
    iow(1'b1);
    `CHK("ign", 1'b0, err_n)
    fail = 1'b0;
    wt(5);
    `CHK("unign", 1'b1, err_n)
    iow(1'b0);
    `CHK("clr", 1'b0, irq)
    $display("test ignore done");
  endtask : t_ign
  task automatic t_ext;
    {mode, ctype} = 2'b10;
    run(1'b0);
    wt(5);
    `CHK("busyreq", 2'h1, {busy_n, req})
    wt(10);
    `CHK("idle", 3'h4, {busy_n, req, irq})
    run(1'b1);
    wt(14);
    `CHK("fault", 4'h2, {busy_n, req, irq, err_n})
    iow(1'b0);
    `CHK("refuse", 1'b1, irq)
    fail = 1'b0;
    wt(5);
    `CHK("latch", 3'h3, {busy_n, err_n, irq})
    iow(1'b0);
    `CHK("clear", 2'h2, {busy_n, irq})
    $display("test external done");
  endtask : t_ext
  task automatic t_third;
    {ctype, intr} = 2'b11;
    wt(5);
    `CHK("coprocessor_interrupt_input", 2'h2, {irq, req})
    intr = 1'b0;
    iow(1'b0);
    `CHK("wclr", 1'b0, irq)
    ctype = 1'b0;
    $display("test third done");
  endtask : t_third
  task automatic t_pres;
    {present, cpu_rst} = 2'b11;
    wt(5);
    `CHK("pres", 1'b0, err_n)
    cpu_rst = 1'b0;
    wt(5);
    `CHK("window", 1'b0, err_n)
    cyc_n = 1'b0;
    wt(3);
    cyc_n = 1'b1;
    wt(5);
    `CHK("first", 1'b1, err_n)
    iow(1'b0);
    {present, cpu_rst} = 2'b01;
    wt(5);
    `CHK("absent", 1'b1, err_n)
    cpu_rst = 1'b0;
    $display("test presence done");
  endtask : t_pres
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  // idle pins, reset for ten cycles, then the scenarios
  initial
  begin
    {rstn_i, mode, ctype, bus_req, intr, rd, hold, ack, pend, mw} = 10'h000;
    {stab, cpu_rst, present, op, fail, be_n} = {5'h00, 4'hf};
    {ken_n, cs_n, wr_n, a0, cyc_n, claim_n} = 6'h3b;
    wt(9);
    `CHK("rst", 11'h5f5, {miss_n, acc, ebe_n, busy_n, req, err_n, irq,
      inv_n})
    wt(1);
    rstn_i = 1'b1;
    wt(2);
    t_ken();
    t_miss();
    t_inv();
    t_ign();
    t_ext();
    t_third();
    t_pres();
    wrap_up();
  end
endmodule : tb_top
